/* File: eifr_pkg.sv */
/*
  Package for the interrupt flag register block: register offsets, field
  positions, reset values, bus encodings and the structs that carry events.
  Assumes a 32-bit AHB-Lite register bus and a single system clock.

*/
package eifr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS      = 8'h00;
  localparam logic [7:0] OFS_FLAGS_CLR  = 8'h04;
  localparam logic [7:0] OFS_ENABLE     = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0c;
  localparam logic [7:0] OFS_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_MARKS      = 8'h14;
  localparam logic [7:0] OFS_RXSTART    = 8'h18;

  // Flag bit positions
  localparam int BIT_TX_BUS_FAULT = 14;
  localparam int BIT_RX_BUS_FAULT = 13;
  localparam int BIT_LOW_MARK     = 9;
  localparam int BIT_HIGH_MARK    = 8;
  localparam int BIT_RX_COMPLETE  = 7;
  localparam int BIT_PKT_WAITING  = 6;
  localparam int BIT_RX_ACTIVITY  = 5;
  localparam int BIT_TX_COMPLETE  = 3;
  localparam int BIT_TX_ABORTED   = 2;
  localparam int BIT_RX_DESC_MISS = 1;
  localparam int BIT_RX_FIFO_OVR  = 0;

  // Implemented flag bits; the rest read zero
  localparam logic [31:0] FLAGS_IMPL   = 32'h0000_63ef;
  // Flags cleared by writing one; the count-driven flags are not
  localparam logic [31:0] FLAGS_W1C    = 32'h0000_60af;
  localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

  // Field positions
  localparam int CTL_ON_BIT        = 15;
  localparam int CTL_DEC_BIT       = 0;
  localparam int MARK_LOW_LSB      = 0;
  localparam int MARK_HIGH_LSB     = 16;
  localparam int STAT_COUNT_LSB    = 16;
  localparam int STAT_MODULE_BIT   = 7;
  localparam int STAT_TX_BIT       = 6;
  localparam int STAT_RX_BIT       = 5;
  localparam int RXSTART_LSB       = 2;

  localparam logic [7:0]  COUNT_MAX    = 8'hff;
  localparam logic [7:0]  COUNT_ZERO   = 8'h00;
  localparam logic [7:0]  MARK_RESET   = 8'h00;
  localparam logic [29:0] RXSTART_RESET = 30'h0000_0000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Event pulses from the DMA engines, MAC and buffer manager
  typedef struct packed {
    logic tx_bus_fault;
    logic rx_bus_fault;
    logic rx_complete;
    logic rx_activity;
    logic tx_complete;
    logic tx_aborted;
    logic rx_desc_missing;
    logic rx_fifo_overrun;
  } eifr_events_t;

  // Engine activity levels for the status register
  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic draining;
  } eifr_activity_t;

  // One register write, decoded
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } eifr_write_t;

endpackage : eifr_pkg

/* File: eifr_ahb_slave.sv */
/*
  AHB-Lite slave front end: captures the address phase and turns each write
  into a one-cycle write strobe with data. Reads answer with zero wait states.
  Assumes single word transfers; the reply is always OKAY.
*/
`timescale 1ns/10ps
module eifr_ahb_slave (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  // Register side
  output eifr_pkg::eifr_write_t     wr,
  output logic                      rd_valid,
  output logic [7:0]                rd_addr
);

  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       take;

  assign take = hsel && hready && (htrans == eifr_pkg::HTRANS_NONSEQ ||
                                   htrans == eifr_pkg::HTRANS_SEQ);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      rd_valid <= 1'b0;
      rd_addr  <= 8'h00;
    end else begin
      wr_pend  <= take && hwrite && hsize == eifr_pkg::HSIZE_WORD;
      wr_addr  <= haddr[7:0];
      rd_valid <= take && !hwrite;
      rd_addr  <= haddr[7:0];
    end
  end

  // Data phase: write data stands now
  always_comb begin
    wr.valid = wr_pend;
    wr.addr  = wr_addr;
    wr.data  = hwdata;
  end

endmodule : eifr_ahb_slave

/* File: eifr_buffer_counter.sv */
/*
  Received buffer counter: saturating up/down count of packet buffers held
  in memory. Assumes increment and decrement are one-cycle pulses.
*/
`timescale 1ns/10ps
module eifr_buffer_counter (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Count control
  input  wire logic       inc,
  input  wire logic       dec,
  input  wire logic       clear,
  // Count
  output logic [7:0]      count
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= eifr_pkg::COUNT_ZERO;
    end else if (clear) begin
      count <= eifr_pkg::COUNT_ZERO;
    end else if (inc && !dec && count != eifr_pkg::COUNT_MAX) begin
      count <= count + 8'h01;
    end else if (dec && !inc && count != eifr_pkg::COUNT_ZERO) begin
      count <= count - 8'h01;
    end
  end

endmodule : eifr_buffer_counter

/* File: eifr_top.sv */
/*
  Interrupt flag register of an Ethernet controller with descriptor DMA.
  Holds the event flags, their enable mask, the receive buffer counter with
  its watermarks, the status register and one level interrupt output.
  Assumes event inputs are one-cycle pulses from logic on hclk, and the
  activity levels come from the same clock domain.
*/
`timescale 1ns/10ps
module eifr_top (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [2:0]            hburst,
  input  wire logic [3:0]            hprot,
  input  wire logic                  hmastlock,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Events and activity
  input  wire eifr_pkg::eifr_events_t   events,
  input  wire eifr_pkg::eifr_activity_t activity,
  input  wire logic                  rx_buffer_done,
  // Controller outputs
  output logic                       irq,
  output logic                       module_on,
  output logic [7:0]                 received_buffer_count
);

  eifr_pkg::eifr_write_t wr;
  logic        rd_valid;
  logic [7:0]  rd_addr;
  logic [31:0] flags;
  logic [31:0] enable;
  logic [31:0] next_flags;
  logic [31:0] ev_vec;
  logic [31:0] clr_vec;
  logic [7:0]  count;
  logic [7:0]  low_level_mark_value;
  logic [7:0]  high_level_mark_value;
  logic [29:0] rx_start;
  logic        buffer_count_decrement;
  logic        start_write;
  logic        module_active_status;
  logic        mark_low;
  logic        mark_high;

  eifr_ahb_slave u_slave (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hsize    (hsize),
    .hready   (hready),
    .hwdata   (hwdata),
    .wr       (wr),
    .rd_valid (rd_valid),
    .rd_addr  (rd_addr)
  );

  // Write strobes with side effects
  assign buffer_count_decrement = wr.valid && wr.addr == eifr_pkg::OFS_CONTROL &&
                                  wr.data[eifr_pkg::CTL_DEC_BIT];
  assign start_write = wr.valid && wr.addr == eifr_pkg::OFS_RXSTART;

  eifr_buffer_counter u_count (
    .hclk    (hclk),
    .hresetn (hresetn),
    .inc     (rx_buffer_done),
    .dec     (buffer_count_decrement),
    .clear   (start_write),
    .count   (count)
  );

  // Watermark compares on the current count
  assign mark_low  = count <= low_level_mark_value;
  assign mark_high = count >= high_level_mark_value;

  // Event pulses placed at their flag positions
  always_comb begin
    ev_vec = 32'h0000_0000;
    ev_vec[eifr_pkg::BIT_TX_BUS_FAULT] = events.tx_bus_fault;
    ev_vec[eifr_pkg::BIT_RX_BUS_FAULT] = events.rx_bus_fault;
    ev_vec[eifr_pkg::BIT_RX_COMPLETE]  = events.rx_complete;
    ev_vec[eifr_pkg::BIT_RX_ACTIVITY]  = events.rx_activity;
    ev_vec[eifr_pkg::BIT_TX_COMPLETE]  = events.tx_complete;
    ev_vec[eifr_pkg::BIT_TX_ABORTED]   = events.tx_aborted;
    ev_vec[eifr_pkg::BIT_RX_DESC_MISS] = events.rx_desc_missing;
    ev_vec[eifr_pkg::BIT_RX_FIFO_OVR]  = events.rx_fifo_overrun;
  end

  // Write-one clear through the clear alias; flags register itself read-only
  assign clr_vec = (wr.valid && wr.addr == eifr_pkg::OFS_FLAGS_CLR) ?
                   (wr.data & eifr_pkg::FLAGS_W1C) : 32'h0000_0000;

  // Sticky flags: a new event wins over a clear in the same cycle
  always_comb begin
    next_flags = ((flags & ~clr_vec) | ev_vec) & eifr_pkg::FLAGS_W1C;
    // Low mark: level sets it, a hardware increment clears it
    if (rx_buffer_done) begin
      next_flags[eifr_pkg::BIT_LOW_MARK] = 1'b0;
    end else begin
      next_flags[eifr_pkg::BIT_LOW_MARK] = flags[eifr_pkg::BIT_LOW_MARK] | mark_low;
    end
    // High mark: level sets it, the decrement command clears it
    if (buffer_count_decrement) begin
      next_flags[eifr_pkg::BIT_HIGH_MARK] = 1'b0;
    end else begin
      next_flags[eifr_pkg::BIT_HIGH_MARK] = flags[eifr_pkg::BIT_HIGH_MARK] | mark_high;
    end
    // Waiting follows the count; a decrement drops it for that cycle
    if (buffer_count_decrement) begin
      next_flags[eifr_pkg::BIT_PKT_WAITING] = 1'b0;
    end else begin
      next_flags[eifr_pkg::BIT_PKT_WAITING] = count != eifr_pkg::COUNT_ZERO;
    end
    next_flags = next_flags & eifr_pkg::FLAGS_IMPL;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= eifr_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Enable mask and marks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable                <= eifr_pkg::ENABLE_RESET;
      low_level_mark_value  <= eifr_pkg::MARK_RESET;
      high_level_mark_value <= eifr_pkg::MARK_RESET;
      module_on             <= 1'b0;
      rx_start              <= eifr_pkg::RXSTART_RESET;
    end else if (wr.valid) begin
      if (wr.addr == eifr_pkg::OFS_ENABLE) begin
        enable <= wr.data & eifr_pkg::FLAGS_IMPL;
      end else if (wr.addr == eifr_pkg::OFS_MARKS) begin
        low_level_mark_value  <= wr.data[eifr_pkg::MARK_LOW_LSB +: 8];
        high_level_mark_value <= wr.data[eifr_pkg::MARK_HIGH_LSB +: 8];
      end else if (wr.addr == eifr_pkg::OFS_CONTROL) begin
        module_on <= wr.data[eifr_pkg::CTL_ON_BIT];
      end else if (wr.addr == eifr_pkg::OFS_RXSTART) begin
        rx_start <= wr.data[31:eifr_pkg::RXSTART_LSB];
      end
    end
  end

  // Interrupt request: any enabled flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & enable);
    end
  end

  // Count mirrored straight from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      received_buffer_count <= eifr_pkg::COUNT_ZERO;
    end else begin
      received_buffer_count <= count;
    end
  end

  assign module_active_status = module_on | activity.draining;

  // Read data, registered into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && !hwrite && htrans[1]) begin
      if (haddr[7:0] == eifr_pkg::OFS_FLAGS || haddr[7:0] == eifr_pkg::OFS_FLAGS_CLR) begin
        hrdata <= flags & eifr_pkg::FLAGS_IMPL;
      end else if (haddr[7:0] == eifr_pkg::OFS_ENABLE) begin
        hrdata <= enable;
      end else if (haddr[7:0] == eifr_pkg::OFS_STATUS) begin
        hrdata <= {8'h00, count, 8'h00, module_active_status,
                   activity.tx_active & module_on, activity.rx_active & module_on, 5'h00};
      end else if (haddr[7:0] == eifr_pkg::OFS_CONTROL) begin
        hrdata <= {16'h0000, module_on, 15'h0000};
      end else if (haddr[7:0] == eifr_pkg::OFS_MARKS) begin
        hrdata <= {8'h00, high_level_mark_value, 8'h00, low_level_mark_value};
      end else if (haddr[7:0] == eifr_pkg::OFS_RXSTART) begin
        hrdata <= {rx_start, 2'b00};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= eifr_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= eifr_pkg::HRESP_OKAY;
    end
  end

endmodule : eifr_top

/* File: eifr_props.sv */
/*
  Port checker for eifr_top: tracks bus data phases and the enable mask.
  Assumes hready is fed from hreadyout and all inputs are on hclk.
*/
`timescale 1ns/10ps
module eifr_props (
  // Clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // Bus
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic                   hready,
  input wire logic [31:0]            hwdata,
  input wire logic [31:0]            hrdata,
  // Events and outputs
  input wire eifr_pkg::eifr_events_t events,
  input wire logic                   rx_buffer_done,
  input wire logic                   irq,
  input wire logic [7:0]             received_buffer_count
);
  logic        wr_ph;
  logic        rd_ph;
  logic [7:0]  ph_addr;
  logic [31:0] en_q;
  logic        st_wr;
  logic [7:0]  cnt;
  assign st_wr = wr_ph && ph_addr == eifr_pkg::OFS_RXSTART;
  assign cnt   = received_buffer_count;
  // Data phase of the transfer taken at the previous edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph   <= 1'b0;
      rd_ph   <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      wr_ph   <= hsel && htrans[1] && hwrite && hsize == eifr_pkg::HSIZE_WORD;
      rd_ph   <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr[7:0];
    end
  end
  // Shadow of the enable mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      en_q <= eifr_pkg::ENABLE_RESET;
    else if (wr_ph && ph_addr == eifr_pkg::OFS_ENABLE)
      en_q <= hwdata & eifr_pkg::FLAGS_IMPL;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cleared;
    ##2 cnt == 8'h00;
  endsequence
  sequence s_quiet;
    !wr_ph && !rx_buffer_done;
  endsequence
  chk_start_clears: assert property (st_wr |-> s_cleared)
    else $error("count not cleared by start write");
  chk_count_step: assert property (!$past(st_wr, 2) |->
    (cnt - $past(cnt)) inside {8'h00, 8'h01, 8'hff}) else $error("count jumped");
  chk_no_wrap: assert property (!$past(st_wr, 2) |->
    !($past(cnt) == 8'hff && cnt == 8'h00) && !($past(cnt) == 8'h00 && cnt == 8'hff))
    else $error("count wrapped");
  chk_flags_unused: assert property (rd_ph && ph_addr[7:3] == 5'h00 |->
    (hrdata & ~eifr_pkg::FLAGS_IMPL) == 32'h0) else $error("unused flag bits set");
  chk_irq_masked: assert property (en_q == 32'h0 && $past(en_q) == 32'h0 |-> !irq)
    else $error("irq with mask clear");
  chk_txbus_irq: assert property (events.tx_bus_fault && en_q[14] && !wr_ph |=> irq)
    else $error("tx bus fault gave no irq");
  chk_rxovr_irq: assert property ($rose(events.rx_fifo_overrun) && en_q[0] && !wr_ph |=> irq)
    else $error("fifo overrun gave no irq");
  chk_irq_sticky: assert property (s_quiet ##1 (irq && !wr_ph && !rx_buffer_done) |=> irq)
    else $error("irq dropped without clear");
endmodule : eifr_props

bind eifr_top eifr_props u_eifr_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .events(events), .rx_buffer_done(rx_buffer_done), .irq(irq),
  .received_buffer_count(received_buffer_count)
);

/* File: testbench.sv */
/*
  Self-checking bench for eifr_top: flags, clear alias, mask, buffer count.
  Assumes the package, design files and eifr_props.sv are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  logic                   hclk;
  logic                   hresetn;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  eifr_pkg::eifr_events_t events;
  logic                   rx_buffer_done;
  logic                   irq;
  logic                   module_on;
  logic [7:0]             received_buffer_count;
  int                     mismatches;
  int                     compares;

  eifr_top u_eifr_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(eifr_pkg::HSIZE_WORD), .hburst(3'h0), .hprot(4'h0),
    .hmastlock(1'b0), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events), .activity(3'h0),
    .rx_buffer_done(rx_buffer_done), .irq(irq), .module_on(module_on),
    .received_buffer_count(received_buffer_count)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t bus never became ready", $time);
    end
  endtask : wait_ready

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d, input logic inc = 1'b0);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= eifr_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b1;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rx_buffer_done <= inc;
    wait_ready;
    if (inc) begin
      rx_buffer_done <= 1'b0;
    end
  endtask : ahb_write

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= eifr_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b0;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    wait_ready;
    check(hrdata & m, exp);
  endtask : rdchk

  task automatic fire(input logic [7:0] e, input logic inc);
    events <= eifr_pkg::eifr_events_t'(e);
    rx_buffer_done <= inc;
    @(posedge hclk);
    events <= '0;
    rx_buffer_done <= 1'b0;
    @(posedge hclk);
  endtask : fire

  task automatic t_reset;
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(eifr_pkg::OFS_FLAGS, 32'hffffffff, 32'h300);
    rdchk(eifr_pkg::OFS_ENABLE, 32'hffffffff, 32'h0);
    check(irq, 1'b0);
    check(received_buffer_count, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_flags;
    int bits [8] = '{14, 13, 7, 5, 3, 2, 1, 0};
    ahb_write(eifr_pkg::OFS_ENABLE, eifr_pkg::FLAGS_W1C);
    for (int i = 0; i < 8; i++) begin
      fire(8'h80 >> i, 1'b0);
      check(irq, 1'b1);
      rdchk(eifr_pkg::OFS_FLAGS, eifr_pkg::FLAGS_W1C, 32'h1 << bits[i]);
      ahb_write(eifr_pkg::OFS_FLAGS, 32'hffffffff);
      rdchk(eifr_pkg::OFS_FLAGS_CLR, 32'hffffffff, (32'h1 << bits[i]) | 32'h300);
      ahb_write(eifr_pkg::OFS_FLAGS_CLR, 32'h1 << bits[i]);
      rdchk(eifr_pkg::OFS_FLAGS, eifr_pkg::FLAGS_W1C, 32'h0);
      check(irq, 1'b0);
    end
    fire(8'h20, 1'b0);
    ahb_write(eifr_pkg::OFS_ENABLE, 32'h0);
    repeat (3) @(posedge hclk);
    check(irq, 1'b0);
    ahb_write(eifr_pkg::OFS_ENABLE, 32'h80);
    repeat (3) @(posedge hclk);
    check(irq, 1'b1);
    ahb_write(eifr_pkg::OFS_FLAGS_CLR, 32'h80);
    repeat (3) @(posedge hclk);
    check(irq, 1'b0);
    $display("flag test done");
  endtask : t_flags

  task automatic t_count;
    ahb_write(eifr_pkg::OFS_MARKS, 32'h0003_0000);
    fire(8'h00, 1'b1);
    rdchk(eifr_pkg::OFS_FLAGS, 32'h340, 32'h140);
    ahb_write(eifr_pkg::OFS_CONTROL, 32'h1);
    // Count-driven flags follow the new count one cycle later
    @(posedge hclk);
    rdchk(eifr_pkg::OFS_FLAGS, 32'h340, 32'h200);
    repeat (3) fire(8'h00, 1'b1);
    rdchk(eifr_pkg::OFS_FLAGS, 32'h340, 32'h140);
    ahb_write(eifr_pkg::OFS_CONTROL, 32'h1, 1'b1);
    rdchk(eifr_pkg::OFS_STATUS, 32'h00ff0000, 32'h00030000);
    ahb_write(eifr_pkg::OFS_CONTROL, 32'h1);
    @(posedge hclk);
    rdchk(eifr_pkg::OFS_FLAGS, 32'h340, 32'h040);
    ahb_write(eifr_pkg::OFS_RXSTART, 32'h1000);
    @(posedge hclk);
    rdchk(eifr_pkg::OFS_FLAGS, 32'h340, 32'h200);
    ahb_write(eifr_pkg::OFS_CONTROL, 32'h1);
    rdchk(eifr_pkg::OFS_STATUS, 32'h00ff0000, 32'h0);
    repeat (256) fire(8'h00, 1'b1);
    rdchk(eifr_pkg::OFS_STATUS, 32'h00ff0000, 32'h00ff0000);
    check(received_buffer_count, 8'hff);
    ahb_write(eifr_pkg::OFS_RXSTART, 32'h0);
    rdchk(eifr_pkg::OFS_STATUS, 32'h00ff0000, 32'h0);
    $display("count test done");
  endtask : t_count

  task automatic t_bus;
    ahb_write(8'h40, 32'hffffffff);
    rdchk(8'h40, 32'hffffffff, 32'h0);
    ahb_write(eifr_pkg::OFS_ENABLE, eifr_pkg::FLAGS_IMPL);
    fire(8'hff, 1'b1);
    check(irq, 1'b1);
    rdchk(eifr_pkg::OFS_FLAGS, 32'hffffffff, 32'h61ef);
    ahb_write(eifr_pkg::OFS_FLAGS_CLR, 32'hffffffff);
    rdchk(eifr_pkg::OFS_FLAGS, 32'hffffffff, 32'h140);
    ahb_write(eifr_pkg::OFS_CONTROL, 32'h8001);
    @(posedge hclk);
    check({module_on, hresp}, 2'b10);
    rdchk(eifr_pkg::OFS_STATUS, 32'h00ff0080, 32'h00000080);
    rdchk(eifr_pkg::OFS_FLAGS, 32'h340, 32'h200);
    $display("bus test done");
  endtask : t_bus

  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    events = '0;
    rx_buffer_done = 1'b0;
    mismatches = 0;
    compares = 0;
    t_reset;
    t_flags;
    t_count;
    t_bus;
    t_reset;
    results;
  end

  // Run should take about 7.5 us
  initial begin
    #200000;
    mismatches++;
    results;
  end
endmodule : testbench
